/* core/rts_pkg.sv */
// Package with register map, bus encodings and timing constants of the thermal sensor.
package rts_pkg;
    localparam logic [7:0] CMD_REMOTE_READING  = 8'h01;
    localparam logic [7:0] CMD_SETUP           = 8'h03;
    localparam logic [7:0] CMD_MAKER_CODE      = 8'hFE;
    localparam logic [7:0] CMD_SILICON_VERSION = 8'hFF;
    localparam logic [7:0] READING_RESET       = 8'h00;
    localparam logic [7:0] READING_FAULT       = 8'h7F;
    localparam int         HALT_BIT_POS        = 6;
    localparam logic       HALT_RESET          = 1'b0;
    localparam logic [6:0] SLAVE_ADDR_DEFAULT  = 7'h48;
    // Arbitrary neutral identity values.
    localparam logic [7:0] MAKER_CODE_DEFAULT  = 8'h5C;
    localparam logic [7:0] VERSION_DEFAULT     = 8'h01;
    localparam int         CLK_HZ              = 50_000_000;
    localparam int         CONV_TIME_US        = 100;
    localparam int         CONV_CYCLES         = CLK_HZ / 1_000_000 * CONV_TIME_US;
endpackage

/* core/rts_conv_if.sv */
// Interface carrying the conversion control and result between the two modules.
`timescale 1ns/1ns
interface rts_conv_if;
    logic       restart;
    logic       halt;
    logic       done;
    logic       fault;
    logic [7:0] sample;
    modport regs (output restart, output halt, input done, input fault, input sample);
    modport conv (input restart, input halt, output done, output fault, output sample);
endinterface

/* core/rts_converter.sv */
// Conversion sequencer: times each conversion and captures the front-end sample.
`timescale 1ns/1ns
module rts_converter
    import rts_pkg::*;
#(
    parameter int CYCLES = CONV_CYCLES
) (
    input  wire logic       clk,      // System clock.
    input  wire logic       rst,      // Synchronous reset, high.
    input  wire logic [7:0] adc_code, // Front-end code, same clock.
    input  wire logic       adc_bad,  // Front-end fault flag.
    rts_conv_if.conv        cv        // Link to the register set.
);
    logic [31:0] count;
    logic        running;
    wire         at_end = running && (count == 32'(CYCLES - 1));

    // A restart throws away the partial count, so no partial result is ever reported.
    always_ff @(posedge clk) begin
        if (rst || cv.restart || cv.halt) begin
            count   <= '0;
            running <= !rst && !cv.halt;
        end else if (at_end) begin
            count   <= '0;
        end else begin
            count   <= count + 32'd1;
            running <= 1'b1;
        end
    end

    // Result strobe at end of conversion; sample and fault are registered every cycle.
    always_ff @(posedge clk) begin
        if (rst) begin
            cv.done   <= 1'b0;
            cv.fault  <= 1'b0;
            cv.sample <= READING_RESET;
        end else begin
            cv.done   <= at_end && !cv.restart && !cv.halt;
            cv.fault  <= adc_bad;
            cv.sample <= adc_code;
        end
    end
endmodule

/* core/rts_top.sv */
// Remote thermal sensor register set behind a 2-wire serial slave.
//
// Function
// - Read-only 8-bit reading at command 01h, zero after reset.
// - Reading is two's complement, one degree per bit.
// - Reading keeps reset value until the first conversion ends.
// - Setup register at 03h; bit 6 is the halt bit.
// - Setup reserved bits are written zero by host and read undefined.
// - Halt bit clears at reset so conversions start.
// - Setup write aborts the conversion in progress, discarding it.
// - After a setup write that leaves the halt bit clear a fresh conversion starts.
// - Maker code at FEh is fixed; writes ignored.
// - Silicon version at FFh is fixed from reset.
// - Reads are write-command, repeated start, read; writes send command then data.
// - Only the own slave address is acknowledged.
// - Halt stops conversions and leaves every register untouched.
// - A sensing fault at conversion end reports plus 127 degrees.
`timescale 1ns/1ns
module rts_top
    import rts_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = SLAVE_ADDR_DEFAULT,
    parameter logic [7:0] MAKER_CODE = MAKER_CODE_DEFAULT,
    parameter logic [7:0] VERSION    = VERSION_DEFAULT,
    parameter int         CYCLES     = CONV_CYCLES
) (
    input  wire logic       CLK,      // System clock, 50 MHz.
    input  wire logic       RST,      // Synchronous reset, high.
    input  wire logic       SCL,      // Serial clock pin.
    input  wire logic       SDA_IN,   // Serial data pin level.
    output logic            SDA_OUT,  // Serial data drive value, always low.
    output logic            SDA_OE,   // Serial data pull-low enable.
    input  wire logic [7:0] ADC_CODE, // Front-end temperature code.
    input  wire logic       ADC_BAD,  // Front-end sensing fault.
    output logic            HALTED    // Halt bit state.
);
    typedef enum {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK,
                  ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK, ST_SKIP} rts_state_type;

    rts_conv_if cv ();

    // Two-stage synchronisers; only the second stage feeds logic.
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic       scl_q;
    logic       sda_q;
    always_ff @(posedge CLK) begin
        scl_sync <= {scl_sync[0], SCL};
        sda_sync <= {sda_sync[0], SDA_IN};
        scl_q    <= scl_sync[1];
        sda_q    <= sda_sync[1];
    end

    wire scl_s   = scl_sync[1];
    wire sda_s   = sda_sync[1];
    wire scl_ris = scl_s && !scl_q;
    wire scl_fal = !scl_s && scl_q;
    wire start_c = scl_s && scl_q && !sda_s && sda_q;
    wire stop_c  = scl_s && scl_q && sda_s && !sda_q;

    rts_state_type state;
    logic [7:0]    shift;
    logic [2:0]    bitcnt;
    logic          rd_mode;
    logic          hold_low;
    logic [7:0]    command;
    logic [7:0]    reading;
    logic          halt;
    logic          restart;
    logic [7:0]    tx_byte;

    wire byte_done = scl_ris && (bitcnt == 3'd7);
    wire [7:0] rx_byte = {shift[6:0], sda_s};
    wire addr_hit = (rx_byte[7:1] == SLAVE_ADDR);
    wire wr_setup = (state == ST_WDATA) && byte_done && (command == CMD_SETUP);

    // Read mux; reserved setup bits return zero here, which the host ignores.
    logic [7:0] read_mux;
    always_comb begin
        case (command)
            CMD_REMOTE_READING:  read_mux = reading;
            CMD_SETUP:           read_mux = 8'(halt) << HALT_BIT_POS;
            CMD_MAKER_CODE:      read_mux = MAKER_CODE;
            CMD_SILICON_VERSION: read_mux = VERSION;
            default:             read_mux = 8'h00;
        endcase
    end

    // Serial slave sequencer, shifting on rising clock and steering data on falling.
    always_ff @(posedge CLK) begin
        if (RST) begin
            state    <= ST_IDLE;
            shift    <= 8'h00;
            bitcnt   <= 3'd0;
            rd_mode  <= 1'b0;
            hold_low <= 1'b0;
            command  <= 8'h00;
            tx_byte  <= 8'h00;
        end else if (start_c) begin
            // A repeated start keeps the command for the read phase.
            state    <= ST_ADDR;
            bitcnt   <= 3'd0;
            hold_low <= 1'b0;
        end else if (stop_c) begin
            state    <= ST_IDLE;
            hold_low <= 1'b0;
        end else begin
            case (state)
                ST_ADDR, ST_CMD, ST_WDATA: begin
                    if (scl_ris) begin
                        shift  <= rx_byte;
                        bitcnt <= bitcnt + 3'd1;
                    end
                    if (byte_done) begin
                        if (state == ST_ADDR) begin
                            rd_mode <= rx_byte[0];
                            state   <= addr_hit ? ST_ADDR_ACK : ST_SKIP;
                        end else if (state == ST_CMD) begin
                            command <= rx_byte;
                            state   <= ST_CMD_ACK;
                        end else begin
                            state   <= ST_WDATA_ACK;
                        end
                    end
                end
                ST_ADDR_ACK, ST_CMD_ACK, ST_WDATA_ACK: begin
                    // Pull low across the ninth clock; after its fall release, or drive data bit 7 when a read follows.
                    if (scl_fal && !hold_low) begin
                        hold_low <= 1'b1;
                        tx_byte  <= read_mux;
                    end else if (scl_fal && hold_low) begin
                        bitcnt <= 3'd0;
                        if (state == ST_ADDR_ACK && rd_mode) begin
                            state    <= ST_RDATA;
                            hold_low <= !tx_byte[7];
                        end else begin
                            // One data byte per write; a later byte must not rewrite setup.
                            hold_low <= 1'b0;
                            state    <= (state == ST_ADDR_ACK) ? ST_CMD :
                                        (state == ST_CMD_ACK)  ? ST_WDATA : ST_SKIP;
                        end
                    end
                end
                ST_RDATA: begin
                    if (scl_ris) begin
                        bitcnt <= bitcnt + 3'd1;
                    end
                    if (scl_fal) begin
                        if (bitcnt == 3'd0) begin
                            hold_low <= 1'b0;
                            state    <= ST_RDATA_ACK;
                        end else begin
                            hold_low <= !tx_byte[3'd7 - bitcnt];
                        end
                    end
                end
                ST_RDATA_ACK: begin
                    // One data byte only; the master's acknowledge is not needed.
                    if (scl_fal) begin
                        state <= ST_SKIP;
                    end
                end
                ST_SKIP: begin
                    hold_low <= 1'b0;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Setup register: only the halt bit is stored, reserved bits are dropped.
    always_ff @(posedge CLK) begin
        if (RST) begin
            halt    <= HALT_RESET;
            restart <= 1'b0;
        end else begin
            if (wr_setup) begin
                halt <= rx_byte[HALT_BIT_POS];
            end
            // Restart pulses once the data byte is in, killing any partial count.
            restart <= wr_setup;
        end
    end

    // Reading changes only on a completed conversion; halt freezes it.
    always_ff @(posedge CLK) begin
        if (RST) begin
            reading <= READING_RESET;
        end else if (cv.done && !restart) begin
            reading <= cv.fault ? READING_FAULT : cv.sample;
        end
    end

    assign cv.restart = restart | wr_setup;
    assign cv.halt    = halt;

    rts_converter #(
        .CYCLES (CYCLES)
    ) u_conv (
        .clk      (CLK),
        .rst      (RST),
        .adc_code (ADC_CODE),
        .adc_bad  (ADC_BAD),
        .cv       (cv)
    );

    assign SDA_OUT = 1'b0;
    assign SDA_OE  = hold_low;
    assign HALTED  = halt;
endmodule

/* dv/rts_top_monitor.sv */
// Checker of serial pin timing and halt state of the thermal sensor.
`timescale 1ns/1ns
module rts_top_monitor (
    input wire logic CLK,     // System clock.
    input wire logic RST,     // Synchronous reset, high.
    input wire logic SCL,     // Serial clock pin.
    input wire logic SDA_OUT, // Serial data drive value.
    input wire logic SDA_OE,  // Serial data pull-low enable.
    input wire logic HALTED   // Halt bit state.
);
    logic       scl_q;
    logic [4:0] idle_cnt;
    // Cycles since the serial clock last moved; saturates so a long idle bus stays idle.
    always_ff @(posedge CLK) begin
        scl_q    <= SCL;
        idle_cnt <= (RST || SCL != scl_q) ? 5'h00 : idle_cnt + {4'h0, idle_cnt != 5'h1F};
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    sequence scl_rise_s; $rose(SCL); endsequence
    sequence oe_hold_s; $stable(SDA_OE) [*2]; endsequence
    a_reset_state: assert property ($fell(RST) |-> !HALTED && !SDA_OE)
        else $error("halt or drive set after reset");
    a_drive_value: assert property (SDA_OE |-> SDA_OUT == 1'b0)
        else $error("data pin driven high");
    a_change_scl_low: assert property ($changed(SDA_OE) |-> !$past(SCL, 2))
        else $error("data drive moved near clock high");
    a_stable_scl_high: assert property (scl_rise_s |=> oe_hold_s)
        else $error("data drive moved while clock high");
    a_bit_width: assert property ($rose(SDA_OE) |-> SDA_OE [*6])
        else $error("driven bit shorter than a bit time");
    a_idle_release: assert property (idle_cnt > 5'd20 |-> !SDA_OE)
        else $error("data driven on an idle bus");
    a_oe_near_edge: assert property ($rose(SDA_OE) |-> idle_cnt < 5'd8)
        else $error("drive started without clock activity");
    a_idle_halt: assert property (idle_cnt > 5'd20 |-> $stable(HALTED))
        else $error("halt state moved on an idle bus");
endmodule
bind rts_top rts_top_monitor mon (.CLK(CLK), .RST(RST), .SCL(SCL), .SDA_OUT(SDA_OUT),
    .SDA_OE(SDA_OE), .HALTED(HALTED));

/* dv/rts_host_model.sv */
// Behavioural two-wire host running byte writes and composite byte reads.
`timescale 1ns/1ns
module rts_host_model (
    input  wire logic clk,      // System clock pacing the bits.
    input  wire logic sda_line, // Resolved data level.
    output logic      scl,      // Serial clock.
    output logic      sda_low   // High while pulling data low.
);
    // Bus idles released; the line has a pull-up.
    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Start when go is high, stop otherwise; data moves while the clock is high.
    task automatic cond(input logic go);
        tick(1);
        sda_low <= ~go;
        tick(4);
        scl <= 1'b1;
        tick(4);
        sda_low <= go;
        tick(4);
        scl <= ~go;
    endtask
    // Long low phase leaves the device time to turn its drive round.
    task automatic bit_io(input logic tx, output logic rx);
        tick(1);
        sda_low <= ~tx;
        tick(4);
        scl <= 1'b1;
        tick(3);
        rx = sda_line;
        scl <= 1'b0;
    endtask
    task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
        logic nak;
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
        bit_io(1'b1, nak);
        ack = ~nak;
    endtask
    // One register access; a read uses a repeated start and ends with a not-acknowledge.
    task automatic xfer(input logic rd, input logic [6:0] addr, input logic [7:0] cmd,
                        input logic [7:0] wdata, output logic [7:0] rdata, output logic ok);
        logic [7:0] rx;
        logic       a0, a1, a2, a3;
        cond(1'b1);
        byte_io({addr, 1'b0}, rx, a0);
        byte_io(cmd, rx, a1);
        if (rd) begin
            cond(1'b1);
            byte_io({addr, 1'b1}, rx, a2);
            byte_io(8'hFF, rdata, a3);
        end else begin
            byte_io(wdata, rdata, a2);
        end
        cond(1'b0);
        ok = a0 & a1 & a2;
    endtask
endmodule

/* dv/tb_rts_top.sv */
// Self-checking bench for the thermal sensor register set.
`timescale 1ns/1ns
`define CHK(got, exp) check_val(got, exp)
module tb_rts_top
    import rts_pkg::*;
;
    localparam int         CYC  = 600;
    localparam logic [6:0] ADDR = SLAVE_ADDR_DEFAULT;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] adc_code = 8'h19;
    logic       adc_bad = 1'b0;
    logic       scl, sda_low, sda_out, sda_oe, halted, ok;
    logic [7:0] rdata;
    logic [7:0] temps [3] = '{8'hE7, 8'h80, 8'h7D};
    int         failures = 0;
    int         num_checks = 0;
    int         cycles = 0;
    wire        sda_line = ~(sda_low | (sda_oe & ~sda_out));
    always #10 clk = ~clk;
    rts_host_model host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
    rts_top #(.CYCLES(CYC)) uut (.CLK(clk), .RST(rst), .SCL(scl), .SDA_IN(sda_line),
        .SDA_OUT(sda_out), .SDA_OE(sda_oe), .ADC_CODE(adc_code), .ADC_BAD(adc_bad),
        .HALTED(halted));
    task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Accesses check the acknowledge; reads then check the masked data against the expectation.
    task automatic rd_chk(input logic [7:0] cmd, input logic [7:0] mask, input logic [7:0] exp);
        host.xfer(1'b1, ADDR, cmd, 8'h00, rdata, ok);
        `CHK({7'h00, ok}, 8'h01);
        `CHK(rdata & mask, exp);
    endtask
    task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
        host.xfer(1'b0, ADDR, cmd, d, rdata, ok);
        `CHK({7'h00, ok}, 8'h01);
    endtask
    // A hang is cut short well beyond the expected length of the run.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            print_verdict();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        rd_chk(CMD_REMOTE_READING, 8'hFF, READING_RESET);
        repeat (CYC + 50) @(posedge clk);
        rd_chk(CMD_REMOTE_READING, 8'hFF, 8'h19);
        foreach (temps[i]) begin
            adc_code <= temps[i];
            repeat (2 * CYC) @(posedge clk);
            rd_chk(CMD_REMOTE_READING, 8'hFF, temps[i]);
        end
        adc_bad <= 1'b1;
        repeat (2 * CYC) @(posedge clk);
        rd_chk(CMD_REMOTE_READING, 8'hFF, READING_FAULT);
        adc_bad <= 1'b0;
        $display("test reading finished");
        rd_chk(CMD_MAKER_CODE, 8'hFF, MAKER_CODE_DEFAULT);
        wr(CMD_MAKER_CODE, 8'h00);
        rd_chk(CMD_MAKER_CODE, 8'hFF, MAKER_CODE_DEFAULT);
        rd_chk(CMD_SILICON_VERSION, 8'hFF, VERSION_DEFAULT);
        // An unused command reads as zero, which a released line could never show.
        rd_chk(8'h02, 8'hFF, 8'h00);
        host.xfer(1'b1, ADDR ^ 7'h01, CMD_MAKER_CODE, 8'h00, rdata, ok);
        `CHK({7'h00, ok}, 8'h00);
        $display("test identity finished");
        rd_chk(CMD_SETUP, 8'h40, 8'h00);
        wr(CMD_SETUP, 8'h40);
        `CHK({7'h00, halted}, 8'h01);
        rd_chk(CMD_SETUP, 8'h40, 8'h40);
        adc_code <= 8'h01;
        repeat (2 * CYC) @(posedge clk);
        rd_chk(CMD_REMOTE_READING, 8'hFF, 8'h7D);
        adc_code <= 8'hFF;
        wr(CMD_SETUP, 8'h00);
        wr(CMD_SETUP, 8'h00);
        `CHK({7'h00, halted}, 8'h00);
        repeat (150) @(posedge clk);
        rd_chk(CMD_REMOTE_READING, 8'hFF, 8'h7D);
        repeat (CYC + 50) @(posedge clk);
        rd_chk(CMD_REMOTE_READING, 8'hFF, 8'hFF);
        $display("test setup finished");
        print_verdict();
    end
endmodule
